// [system_reset_sequencer.sv]
// system reset sequencer: collects reset sources and drives held logic
// assumes sources are levels, held until the cause is gone
module system_reset_sequencer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [rst_seq_pkg::N_SRC-1:0] src_raw,
   input wire logic retain_en,
   input wire logic reset_pin_n_in,
   output logic reset_pin_n_out,
   output logic reset_pin_n_oe_n,
   output rst_seq_pkg::rst_ctrl_t ctrl,
   output rst_seq_pkg::port_def_t port_def,
   output logic retain_hold,
   output logic [rst_seq_pkg::N_SRC-1:0] reset_cause
);
   import rst_seq_pkg::*;

   seq_t q_r;
   seq_t q_nxt;
   logic any_src;
   logic pin_src;
   logic [N_SRC-1:0] src_now;

   // causes that drive the pin
   // both the next-state logic and the pin checks below decode these
   function automatic logic drives_pin(input logic [N_SRC-1:0] c);
      return c[SRC_POR] | c[SRC_SUP];
   endfunction : drives_pin

   ////////////////////////////////////////////////////////////////////
   // pin source merge
   // the pin has a two-flop synchroniser of its own; our drive, and the two
   // cycles the released pin needs to clear that synchroniser, are masked
   // so the device cannot hold itself in reset through its own pin
   always_comb begin
      pin_src = ~q_r.pin_sync[1] & ~q_r.pin_drive & ~|q_r.drive_hist;
      src_now = q_r.s2;
      src_now[SRC_PIN] = q_r.s2[SRC_PIN] | pin_src;
   end

   always_comb begin
      q_nxt = q_r;
      q_nxt.s1 = src_raw;
      q_nxt.s2 = q_r.s1;
      q_nxt.pin_sync = {q_r.pin_sync[0], reset_pin_n_in};
      q_nxt.drive_hist = {q_r.drive_hist[0], q_r.pin_drive};
      any_src = |src_now;
      unique case (q_r.st)
         ST_RUN: begin
            // retention request
            // sampled only while running, so a reset keeps the choice made before it
            q_nxt.retain_req = retain_en;
            if (any_src) begin
               q_nxt.st = ST_HOLD;
               q_nxt.cause = src_now;
            end
         end
         ST_HOLD: begin
            q_nxt.cause = q_r.cause | src_now;
            q_nxt.cnt = '0;
            // wait for every source to clear
            if (!any_src) begin
               q_nxt.st = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            if (any_src) begin
               q_nxt.st = ST_HOLD;
               q_nxt.cause = q_r.cause | src_now;
            end else if (q_r.cnt == 2'(RELEASE_CYC - 1)) begin
               q_nxt.st = ST_RUN;
            end else begin
               q_nxt.cnt = q_r.cnt + 2'h1;
            end
         end
      endcase
      if (q_nxt.st != ST_RUN) begin
         q_nxt.ctrl.core_hold = 1'b1;
         q_nxt.ctrl.periph_rst = 1'b1;
         q_nxt.ctrl.por_rst = q_nxt.cause[SRC_POR];
         q_nxt.ctrl.irq_disable = 1'b1;
         q_nxt.ctrl.timer_disable = 1'b1;
         q_nxt.ctrl.ram_we_block = 1'b1;
         q_nxt.ctrl.pc_load = PC_RESET;
         q_nxt.ctrl.clk_sel = CLKSEL_INTERNAL;
         q_nxt.ctrl.wdt_enable = 1'b1;
         q_nxt.port.latch = PORT_LATCH_RESET;
         q_nxt.port.od_n = PORT_CFG_RESET;
         q_nxt.port.pullup_en = 1'b1;
         q_nxt.retain_hold = q_r.retain_req & ~q_nxt.cause[SRC_POR];
         // pin low for power-on and supply
         q_nxt.pin_drive = drives_pin(q_nxt.cause);
      end else begin
         q_nxt.ctrl.core_hold = 1'b0;
         q_nxt.ctrl.periph_rst = 1'b0;
         q_nxt.ctrl.por_rst = 1'b0;
         q_nxt.ctrl.irq_disable = 1'b0;
         q_nxt.ctrl.timer_disable = 1'b0;
         q_nxt.ctrl.ram_we_block = 1'b0;
         q_nxt.pin_drive = 1'b0;
         q_nxt.retain_hold = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= '0;
         q_r.st <= ST_HOLD;
         q_r.cause <= N_SRC'(1) << SRC_POR;
         // idle level of the pin, so no false pin source follows reset
         q_r.pin_sync <= '1;
         q_r.pin_drive <= 1'b1;
         q_r.ctrl.core_hold <= 1'b1;
         q_r.ctrl.periph_rst <= 1'b1;
         q_r.ctrl.por_rst <= 1'b1;
         q_r.ctrl.irq_disable <= 1'b1;
         q_r.ctrl.timer_disable <= 1'b1;
         q_r.ctrl.ram_we_block <= 1'b1;
         q_r.ctrl.wdt_enable <= 1'b1;
         q_r.ctrl.pc_load <= PC_RESET;
         q_r.ctrl.clk_sel <= CLKSEL_INTERNAL;
         q_r.port.latch <= PORT_LATCH_RESET;
         q_r.port.od_n <= PORT_CFG_RESET;
         q_r.port.pullup_en <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign reset_pin_n_out = 1'b0;
   assign reset_pin_n_oe_n = ~q_r.pin_drive;
   assign ctrl = q_r.ctrl;
   assign port_def = q_r.port;
   assign retain_hold = q_r.retain_hold;
   assign reset_cause = q_r.cause;

   ////////////////////////////////////////////////////////////////////
   // core held
   AST_HOLD_CORE: assert property (@(posedge clk) disable iff (rst)
      (q_r.st != ST_RUN) |-> ctrl.core_hold) else $error("core not held");
   AST_ENTER: assert property (@(posedge clk) disable iff (rst)
      (q_r.st == ST_RUN && |src_now) |=> ctrl.core_hold) else $error("no entry");
   AST_CAUSE: assert property (@(posedge clk) disable iff (rst)
      (q_r.st == ST_RUN && |src_now) |=> (reset_cause == $past(src_now)))
      else $error("reset cause not captured");
   AST_POR_ONLY: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold |-> (ctrl.periph_rst && ctrl.por_rst == reset_cause[SRC_POR]))
      else $error("power-on reset flag wrong");
   AST_IRQ_OFF: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold |-> (ctrl.irq_disable && ctrl.timer_disable))
      else $error("irq live in reset");
   AST_RUN_FREE: assert property (@(posedge clk) disable iff (rst)
      !ctrl.core_hold |-> !(ctrl.irq_disable || ctrl.timer_disable || ctrl.periph_rst))
      else $error("held logic not released");
   AST_RAM: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold == ctrl.ram_we_block)
      else $error("ram write block wrong");
   AST_PORT: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold |-> (port_def.latch == PORT_LATCH_RESET && port_def.pullup_en))
      else $error("port default");
   AST_PORT_OD: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold |-> (port_def.od_n == PORT_CFG_RESET))
      else $error("port not open drain");
   AST_RETAIN: assert property (@(posedge clk) disable iff (rst)
      (ctrl.core_hold && reset_cause[SRC_POR]) |-> !retain_hold)
      else $error("retain on por");
   AST_RETAIN_RUN: assert property (@(posedge clk) disable iff (rst)
      !ctrl.core_hold |-> !retain_hold)
      else $error("retain held in run");
   AST_PIN: assert property (@(posedge clk) disable iff (rst)
      (ctrl.core_hold && drives_pin(reset_cause)) |-> !reset_pin_n_oe_n)
      else $error("pin not driven");
   AST_PIN_REL: assert property (@(posedge clk) disable iff (rst)
      !ctrl.core_hold |-> reset_pin_n_oe_n) else $error("pin driven in run");
   AST_PC_HOLD: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold |-> (ctrl.pc_load == PC_RESET))
      else $error("pc not cleared");
   AST_PC: assert property (@(posedge clk) disable iff (rst)
      $fell(ctrl.core_hold) |-> (ctrl.pc_load == PC_RESET && ctrl.wdt_enable
      && ctrl.clk_sel == CLKSEL_INTERNAL)) else $error("bad start state");
   AST_CLK: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold |-> (ctrl.clk_sel == CLKSEL_INTERNAL))
      else $error("clock not internal");
   AST_WDT: assert property (@(posedge clk) disable iff (rst)
      ctrl.core_hold |-> ctrl.wdt_enable)
      else $error("watchdog off");
   AST_WAIT: assert property (@(posedge clk) disable iff (rst)
      (ctrl.core_hold && |src_now) |=> ctrl.core_hold) else $error("early release");
   AST_HOLD_LEN: assert property (@(posedge clk) disable iff (rst)
      $fell(ctrl.core_hold) |-> ($past(q_r.st) == ST_RELEASE))
      else $error("release skipped count");
   // cover points: power-on, watchdog, pin and supply resets, retention
   COV_POR: cover property (@(posedge clk) $fell(ctrl.core_hold) && reset_cause[SRC_POR]);
   COV_WDT: cover property (@(posedge clk) $rose(ctrl.core_hold) && reset_cause[SRC_WDT]);
   COV_PIN: cover property (@(posedge clk) $rose(ctrl.core_hold) && reset_cause[SRC_PIN]);
   COV_SUP: cover property (@(posedge clk) $fell(ctrl.core_hold) && reset_cause[SRC_SUP]);
   COV_RET: cover property (@(posedge clk) retain_hold);
endmodule : system_reset_sequencer

// [rst_seq_pkg.sv]
// constants and carrier types for the system reset sequencer
// assumes one 25 MHz clock; reset sources arrive as raw levels from other domains
// Operation
// - core is held, no fetch or execute, while any reset is active.
// - registers take reset values; power-on-only bits clear only on power-on.
// - all interrupt sources and timers are disabled on reset entry.
// - data RAM contents are never touched by the reset sequence.
// - port latches read one, open-drain mode, weak pull-up on, in reset.
// - retained port, converter and reference state survive non-power-on resets.
// - power-on and supply resets drive the reset pin low until exit.
// - program counter cleared so first fetch is from code address zero.
// - internal oscillator selected as system clock on reset exit.
// - watchdog is enabled and running on reset exit.
// - any of eight sources asserted puts the device into reset.
package rst_seq_pkg;
   localparam int unsigned N_SRC = 8;
   localparam int unsigned SRC_POR = 0;
   localparam int unsigned SRC_PIN = 1;
   localparam int unsigned SRC_CMP = 2;
   localparam int unsigned SRC_SW = 3;
   localparam int unsigned SRC_SUP = 4;
   localparam int unsigned SRC_WDT = 5;
   localparam int unsigned SRC_MCD = 6;
   localparam int unsigned SRC_FLE = 7;
   localparam int unsigned PC_W = 16;
   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   localparam logic [1:0] CLKSEL_INTERNAL = 2'h0;
   localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
   localparam logic [7:0] PORT_CFG_RESET = 8'h00;
   localparam int unsigned RELEASE_CYC = 2;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_HOLD,
      ST_RELEASE
   } seq_state_t;

   typedef struct packed {
      logic core_hold;
      logic periph_rst;
      logic por_rst;
      logic irq_disable;
      logic timer_disable;
      logic wdt_enable;
      logic ram_we_block;
      logic [PC_W-1:0] pc_load;
      logic [1:0] clk_sel;
   } rst_ctrl_t;

   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] od_n;
      logic pullup_en;
   } port_def_t;

   typedef struct packed {
      logic [N_SRC-1:0] s1;
      logic [N_SRC-1:0] s2;
      seq_state_t st;
      logic [1:0] cnt;
      logic pin_drive;
      logic retain_req;
      logic [1:0] pin_sync;
      logic [1:0] drive_hist;
      logic [N_SRC-1:0] cause;
      logic retain_hold;
      rst_ctrl_t ctrl;
      port_def_t port;
   } seq_t;
endpackage : rst_seq_pkg

// [held_logic_model.sv]
// far-side model: core fetch unit and the open-drain reset pin wire
// assumes ctrl from the sequencer; the pin wire has an external pull-up
module held_logic_model (
   input wire logic clk,
   input wire rst_seq_pkg::rst_ctrl_t ctrl,
   input wire logic pin_out,
   input wire logic pin_oe_n,
   input wire logic ext_low,
   output logic pin_level,
   output logic fetch_v,
   output logic [15:0] fetch_a
);
   timeunit 1ns;
   timeprecision 1ns;
   import rst_seq_pkg::*;
   logic [15:0] pc_r;
   ////////////////////////////////////////////////////////////////////////
   // wired-and pin
   // pull-up wins unless the device or the board sinks the wire
   assign pin_level = !(ext_low || (!pin_oe_n && !pin_out));
   assign fetch_v = !ctrl.core_hold;
   assign fetch_a = pc_r;
   always_ff @(posedge clk) begin
      pc_r <= ctrl.core_hold ? ctrl.pc_load : pc_r + 16'h0001;
   end
endmodule : held_logic_model

// [system_reset_sequencer_tb.sv]
// testbench for the reset sequencer: every source asserted and released
// assumes the far-side model drives the pin wire and fetches on release
module system_reset_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rst_seq_pkg::*;
   logic clk, rst, retain_en, ext_low, pin_level, pin_out, oe_n, hold, fv, re;
   logic [N_SRC-1:0] src_raw, cause;
   logic [15:0] fa;
   rst_ctrl_t ctrl;
   port_def_t port_def;
   int mismatches, n_tests, n, i;
   int cause_q[$];
   // two-flop source synchroniser stages seen before the hold state reacts
   localparam int SYNC_CYC = 2;
   ////////////////////////////////////////////////////////////////////////
   system_reset_sequencer uut (.clk(clk), .rst(rst), .src_raw(src_raw),
      .retain_en(retain_en), .reset_pin_n_in(pin_level), .reset_pin_n_out(pin_out),
      .reset_pin_n_oe_n(oe_n), .ctrl(ctrl), .port_def(port_def),
      .retain_hold(hold), .reset_cause(cause));
   held_logic_model far (.clk(clk), .ctrl(ctrl), .pin_out(pin_out), .pin_oe_n(oe_n),
      .ext_low(ext_low), .pin_level(pin_level), .fetch_v(fv), .fetch_a(fa));
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   // bounded wait; edges counted from the drop of the last source
   task automatic wait_free(output int k);
      k = 0;
      while (ctrl.core_hold !== 1'b0) begin
         @(negedge clk);
         k++;
         if (k > 20) begin
            mismatches++;
            give_verdict();
         end
      end
   endtask : wait_free
   task automatic out_chk(input int exp_n);
      chk("release_edges", 32'(exp_n), 32'(n));
      chk("first_fetch", 32'(PC_RESET), 32'({fv, fa}) ^ 32'h10000);
      chk("clk_sel", 32'(CLKSEL_INTERNAL), 32'(ctrl.clk_sel));
      chk("wdt_enable", 32'h1, 32'(ctrl.wdt_enable));
      chk("pin_free", 32'h1, 32'(oe_n));
      chk("port_after", 32'({PORT_LATCH_RESET, PORT_CFG_RESET, 1'b1}), 32'(port_def));
   endtask : out_chk
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 0; rst = 1; src_raw = '0; retain_en = 0; ext_low = 0;
      mismatches = 0; n_tests = 0;
      void'($urandom(32'h0460ce27));
      repeat (10) @(negedge clk);
      chk("por_pin", 32'h0, 32'(oe_n));
      chk("por_cause", 32'h1, 32'(cause[SRC_POR]));
      rst = 0;
      wait_free(n);
      // after power-on only the hold-to-release edge precedes the release count
      out_chk(RELEASE_CYC + 1);
      $display("test power-on release done");
      // power-on source last so it cannot mask retention of the others
      for (int k = 1; k <= N_SRC; k++) begin
         i = k % N_SRC;
         re = 1'($urandom % 2);
         retain_en = re;
         repeat (2) @(negedge clk);
         if (i == SRC_PIN) ext_low = 1; else src_raw[i] = 1;
         cause_q.push_back(i);
         repeat (2) @(negedge clk);
         chk("hold_early", 32'h0, 32'(ctrl.core_hold));
         @(negedge clk);
         chk("core_hold", 32'h1, 32'(ctrl.core_hold));
         chk("irq_tmr_off", 32'h3, 32'({ctrl.irq_disable, ctrl.timer_disable}));
         chk("regs_ram", 32'h3, 32'({ctrl.periph_rst, ctrl.ram_we_block}));
         chk("pc_load", 32'(PC_RESET), 32'(ctrl.pc_load));
         chk("port_held", 32'({PORT_LATCH_RESET, PORT_CFG_RESET, 1'b1}), 32'(port_def));
         chk("pin_drive", 32'(!(i == SRC_SUP || i == SRC_POR)), 32'(oe_n));
         chk("pin_level", 32'(!(i == SRC_SUP || i == SRC_POR || i == SRC_PIN)),
            32'(pin_level));
         chk("por_rst", 32'(i == SRC_POR), 32'(ctrl.por_rst));
         chk("retain", 32'(re && i != SRC_POR), 32'(hold));
         chk("cause", 32'h1 << cause_q.pop_front(), 32'(cause));
         if (i == SRC_PIN) ext_low = 0; else src_raw[i] = 0;
         wait_free(n);
         out_chk(RELEASE_CYC + SYNC_CYC + 1);
         $display("test source %0d done", i);
      end
      // a power-on reset in mid-run drops retention and every earlier cause
      retain_en = 1;
      repeat (2) @(negedge clk);
      rst = 1;
      repeat (2) @(negedge clk);
      chk("midrun_cause", 32'h1 << SRC_POR, 32'(cause));
      chk("midrun_retain", 32'h0, 32'(hold));
      chk("midrun_pin", 32'h0, 32'(oe_n));
      rst = 0;
      wait_free(n);
      out_chk(RELEASE_CYC + 1);
      $display("test mid-run power-on done");
      give_verdict();
   end
endmodule : system_reset_sequencer_tb
